/* File: design/sai_device.sv */
// The register offsets and the strobed register port were left to the implementer.
`timescale 1ns/100ps
// Function
// RL1 - host resets converter at power-up; the host pulses reset_n only on a control register reset command
// RL2 - reset clears approximation, result, ready
// RL3 - 8-bit three-state data port
// RL4 - byte select picks high or low
// RL5 - result latch separate from approximation register
// RL6 - ready rises when latch loads
// RL7 - high byte read clears ready
// RL8 - ready kept without high read
// RL9 - new result overwrites, ready stays
// RL10 - 16-bit serial output with strobe
// RL11 - 16 strobe falls, 200ns after data
// RL12 - busy high during conversion
// RL13 - busy valid 110ns after write
// RL14 - strobes ignored without chip select
// RL15 - write falling edge starts conversion
// RL16 - drivers on only while reading
// RL17 - two's complement when selected
// RL18 - internal sequencing clock, not exported
// RL19 - busy unfit for sample-hold control
// RL20 - offset binary otherwise, msb not inverted
// RL21 - high byte bits 15:8, msb first
module sai_device #(
  parameter int DATA_W = sai_pkg::DATA_W
) (
  // system
  input  wire logic              CLK,
  input  wire logic              RST_N,
  // converter pins
  sai_if.dev                     LINK,
  // analog side
  input  wire logic              COMP_KEEP,
  input  wire logic              TWOS_SEL,
  output logic      [DATA_W-1:0] TRIAL_WORD
);
  generate
    if (DATA_W != 2 * sai_pkg::BYTE_W) begin : g_bad_width
      $error("data width must be two bytes");
    end
    if (sai_pkg::BIT_CYC > 16 ||
        sai_pkg::FALL_PH >= sai_pkg::BIT_CYC - 1) begin : g_bad_phase
      $error("bit period too short for strobe");
    end
    if (sai_pkg::START_LAT_CYC > sai_pkg::STATUS_CYC) begin : g_bad_lat
      $error("busy latency exceeds status time");
    end
  endgenerate

  localparam logic [3:0] PH_DECIDE = 4'(sai_pkg::DECIDE_PH);
  localparam logic [3:0] PH_FALL = 4'(sai_pkg::FALL_PH);
  localparam logic [3:0] PH_LAST = 4'(sai_pkg::BIT_CYC - 1);
  localparam logic [3:0] BIT_MSB = 4'(DATA_W - 1);

  sai_pkg::sai_dev_state_t st_reg;
  logic [5:0]        pin_raw;
  logic [5:0]        syn1_reg;
  logic [5:0]        syn2_reg;
  logic [5:0]        prev_reg;
  logic [3:0]        phase_reg;
  logic [3:0]        bit_reg;
  logic [DATA_W-1:0] approx_reg;
  logic [DATA_W-1:0] result_reg;
  logic              ready_reg;
  logic              busy_reg;
  logic              ser_data_reg;
  logic              ser_strobe_reg;
  logic [7:0]        data_reg;
  logic              oe_reg;
  logic              cs_on;
  logic              wr_fall;
  logic              rd_on;
  logic              rd_fall;
  logic              pin_rst;
  logic              twos;
  logic              start;
  logic              phase_end;
  logic [DATA_W-1:0] coded;

  assign pin_raw = {LINK.cs_n, LINK.wr_n, LINK.rd_n,
                    LINK.high_byte_select, LINK.reset_n, TWOS_SEL};

  // every pin except COMP_KEEP passes two flops before use
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      syn1_reg <= sai_pkg::PIN_RST_VAL;
      syn2_reg <= sai_pkg::PIN_RST_VAL;
      prev_reg <= sai_pkg::PIN_RST_VAL;
    end else begin
      syn1_reg <= pin_raw;
      syn2_reg <= syn1_reg;
      prev_reg <= syn2_reg;
    end
  end

  // RL14 gate by select
  assign cs_on = !syn2_reg[sai_pkg::I_CS];
  // RL15 write edge
  assign wr_fall = cs_on && !syn2_reg[sai_pkg::I_WR] &&
                   prev_reg[sai_pkg::I_WR];
  assign rd_on = cs_on && !syn2_reg[sai_pkg::I_RD];
  assign rd_fall = rd_on && prev_reg[sai_pkg::I_RD];
  assign pin_rst = !syn2_reg[sai_pkg::I_RST];
  assign twos = syn2_reg[sai_pkg::I_TWOS];
  // a write during a conversion is ignored, not restarted
  assign start = st_reg == sai_pkg::DS_IDLE && wr_fall && !pin_rst;
  assign phase_end = phase_reg == PH_LAST;

  // RL17 twos complement msb
  // RL20 offset binary default
  assign coded = {approx_reg[DATA_W-1] ^ twos, approx_reg[DATA_W-2:0]};

  // RL18 sequenced by local clock
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_reg <= sai_pkg::DS_IDLE;
    end else if (pin_rst) begin
      st_reg <= sai_pkg::DS_IDLE;
    end else begin
      unique case (st_reg)
        sai_pkg::DS_IDLE: begin
          if (start) begin
            st_reg <= sai_pkg::DS_CONV;
          end
        end
        sai_pkg::DS_CONV: begin
          if (phase_end && bit_reg == 4'h0) begin
            st_reg <= sai_pkg::DS_LOAD;
          end
        end
        sai_pkg::DS_LOAD: st_reg <= sai_pkg::DS_IDLE;
        default: st_reg <= sai_pkg::DS_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      phase_reg <= 4'h0;
    end else if (st_reg != sai_pkg::DS_CONV || phase_end) begin
      phase_reg <= 4'h0;
    end else begin
      phase_reg <= phase_reg + 4'h1;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      bit_reg <= BIT_MSB;
    end else if (st_reg != sai_pkg::DS_CONV) begin
      bit_reg <= BIT_MSB;
    end else if (phase_end) begin
      bit_reg <= bit_reg - 4'h1;
    end
  end

  // RL2 reset clears approximation
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      approx_reg <= '0;
    end else if (pin_rst) begin
      approx_reg <= '0;
    end else if (start) begin
      approx_reg <= {1'b1, {(DATA_W - 1){1'b0}}};
    end else if (st_reg == sai_pkg::DS_CONV) begin
      if (phase_reg == PH_DECIDE) begin
        approx_reg[bit_reg] <= COMP_KEEP;
      end else if (phase_end && bit_reg != 4'h0) begin
        approx_reg[bit_reg - 4'h1] <= 1'b1;
      end
    end
  end

  // RL5 separate result latch
  // RL9 overwrite unread word
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      result_reg <= '0;
    end else if (pin_rst) begin
      result_reg <= '0;
    end else if (st_reg == sai_pkg::DS_LOAD) begin
      result_reg <= coded;
    end
  end

  // load wins over a same-cycle high byte read
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ready_reg <= 1'b0;
    end else if (pin_rst) begin
      ready_reg <= 1'b0;
    end else if (st_reg == sai_pkg::DS_LOAD) begin
      // RL6 ready on load
      ready_reg <= 1'b1;
    end else if (rd_fall && syn2_reg[sai_pkg::I_HBS]) begin
      // RL7 high read clears
      // RL8 low read keeps
      ready_reg <= 1'b0;
    end
  end

  // RL12 busy while converting
  // RL13 busy within status time
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      busy_reg <= 1'b0;
    end else if (pin_rst || st_reg == sai_pkg::DS_LOAD) begin
      busy_reg <= 1'b0;
    end else if (start) begin
      busy_reg <= 1'b1;
    end
  end

  // RL10 serial bit out
  // RL21 msb first
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ser_data_reg <= 1'b0;
    end else if (st_reg == sai_pkg::DS_CONV &&
                 phase_reg == PH_DECIDE) begin
      ser_data_reg <= (bit_reg == BIT_MSB) ? (COMP_KEEP ^ twos)
                                           : COMP_KEEP;
    end
  end

  // RL11 one fall per bit
  // strobe idles high so each bit gives exactly one fall
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ser_strobe_reg <= 1'b1;
    end else if (st_reg != sai_pkg::DS_CONV || phase_end) begin
      ser_strobe_reg <= 1'b1;
    end else if (phase_reg == PH_FALL) begin
      ser_strobe_reg <= 1'b0;
    end
  end

  // RL3 byte port enable
  // RL16 drive during read
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      oe_reg <= 1'b0;
      data_reg <= 8'h00;
    end else if (rd_on && !pin_rst) begin
      oe_reg <= 1'b1;
      // RL4 byte select
      data_reg <= syn2_reg[sai_pkg::I_HBS] ? result_reg[15:8]
                                           : result_reg[7:0];
    end else begin
      oe_reg <= 1'b0;
      data_reg <= 8'h00;
    end
  end

  assign LINK.data = data_reg;
  assign LINK.data_oe = oe_reg;
  assign LINK.data_ready = ready_reg;
  assign LINK.busy = busy_reg;
  assign LINK.ser_data = ser_data_reg;
  assign LINK.ser_strobe = ser_strobe_reg;
  assign TRIAL_WORD = approx_reg;
endmodule // sai_device

/* File: design/sai_pkg.sv */
package sai_pkg;
  // word layout
  localparam int DATA_W = 16;
  localparam int BYTE_W = 8;
  // timing at a 25 ns clock
  localparam int CLK_NS = 25;
  localparam int STROBE_DLY_NS = 200;
  localparam int STROBE_DLY_CYC = (STROBE_DLY_NS + CLK_NS - 1) / CLK_NS;
  localparam int STATUS_NS = 110;
  localparam int STATUS_CYC = STATUS_NS / CLK_NS;
  localparam int START_LAT_CYC = 3;
  localparam int BIT_CYC = 16;
  localparam int DECIDE_PH = 3;
  localparam int FALL_PH = DECIDE_PH + STROBE_DLY_CYC;
  // device pin sync vector
  localparam int PIN_N = 6;
  localparam int I_CS = 5;
  localparam int I_WR = 4;
  localparam int I_RD = 3;
  localparam int I_HBS = 2;
  localparam int I_RST = 1;
  localparam int I_TWOS = 0;
  localparam logic [5:0] PIN_RST_VAL = 6'h3A;
  // host pin sync vector
  localparam int HIN_N = BYTE_W + 4;
  localparam int H_STRB = 0;
  localparam int H_SDAT = 1;
  localparam int H_BUSY = 2;
  localparam int H_RDY = 3;
  localparam int H_DATA = 4;
  localparam logic [11:0] HIN_RST_VAL = 12'h001;
  // host sequencing counts
  localparam logic [3:0] WR_LOW = 4'h3;
  localparam logic [3:0] WR_LAST = 4'h4;
  localparam logic [3:0] RD_LOW = 4'h8;
  localparam logic [3:0] RD_SAMPLE = 4'h7;
  localparam logic [3:0] RD_LAST = 4'h9;
  localparam logic [3:0] RST_LAST = 4'h3;
  // host register map
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_RESULT = 4'h8;
  localparam logic [3:0] REG_SERIAL = 4'hC;
  localparam int CTL_START = 0;
  localparam int CTL_READ = 1;
  localparam int CTL_RESET = 2;
  localparam int STS_BUSY = 0;
  localparam int STS_READY = 1;
  localparam int STS_ENG = 2;
  typedef enum logic [1:0] {
    DS_IDLE = 2'b00,
    DS_CONV = 2'b01,
    DS_LOAD = 2'b11
  } sai_dev_state_t;
  typedef enum logic [2:0] {
    HS_IDLE  = 3'b000,
    HS_WRITE = 3'b001,
    HS_RD_LO = 3'b010,
    HS_RD_HI = 3'b110,
    HS_RESET = 3'b100
  } sai_host_state_t;
endpackage

/* File: design/sai_if.sv */
`timescale 1ns/100ps
interface sai_if;
  logic       cs_n;
  logic       wr_n;
  logic       rd_n;
  logic       high_byte_select;
  logic       reset_n;
  logic [7:0] data;
  logic       data_oe;
  logic       data_ready;
  logic       busy;
  logic       ser_data;
  logic       ser_strobe;
  modport dev (
    input  cs_n, wr_n, rd_n, high_byte_select, reset_n,
    output data, data_oe, data_ready, busy, ser_data, ser_strobe
  );
  modport host (
    output cs_n, wr_n, rd_n, high_byte_select, reset_n,
    input  data, data_oe, data_ready, busy, ser_data, ser_strobe
  );
endinterface

/* File: design/sai_host.sv */
`timescale 1ns/100ps
module sai_host (
  // system
  input  wire logic        CLK,
  input  wire logic        RST_N,
  // converter pins
  sai_if.host              LINK,
  // software port
  input  wire logic [3:0]  ADDR,
  input  wire logic [15:0] WDATA,
  input  wire logic        WR_STB,
  input  wire logic        RD_STB,
  output logic      [15:0] RDATA
);
  sai_pkg::sai_host_state_t st_reg;
  logic [3:0]  cnt_reg;
  logic [11:0] hin_raw;
  logic [11:0] syn1_reg;
  logic [11:0] syn2_reg;
  logic        strb_prev_reg;
  logic        cs_n_reg;
  logic        wr_n_reg;
  logic        rd_n_reg;
  logic        hbs_reg;
  logic        rst_n_reg;
  logic [15:0] result_reg;
  logic [15:0] serial_reg;
  logic [15:0] rdata_reg;
  logic        ctl_wr;
  logic        seq_end;

  assign hin_raw = {LINK.data, LINK.data_ready, LINK.busy,
                    LINK.ser_data, LINK.ser_strobe};
  assign ctl_wr = WR_STB && ADDR == sai_pkg::REG_CTRL;

  // device flags are foreign to this clock
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      syn1_reg <= sai_pkg::HIN_RST_VAL;
      syn2_reg <= sai_pkg::HIN_RST_VAL;
      strb_prev_reg <= 1'b1;
    end else begin
      syn1_reg <= hin_raw;
      syn2_reg <= syn1_reg;
      strb_prev_reg <= syn2_reg[sai_pkg::H_STRB];
    end
  end

  always_comb begin
    unique case (st_reg)
      sai_pkg::HS_WRITE: seq_end = cnt_reg == sai_pkg::WR_LAST;
      sai_pkg::HS_RD_LO,
      sai_pkg::HS_RD_HI: seq_end = cnt_reg == sai_pkg::RD_LAST;
      sai_pkg::HS_RESET: seq_end = cnt_reg == sai_pkg::RST_LAST;
      default:           seq_end = 1'b0;
    endcase
  end

  // commands arriving while a sequence runs are dropped
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_reg <= sai_pkg::HS_IDLE;
    end else begin
      unique case (st_reg)
        sai_pkg::HS_IDLE: begin
          if (ctl_wr && WDATA[sai_pkg::CTL_RESET]) begin
            st_reg <= sai_pkg::HS_RESET;
          end else if (ctl_wr && WDATA[sai_pkg::CTL_START]) begin
            st_reg <= sai_pkg::HS_WRITE;
          end else if (ctl_wr && WDATA[sai_pkg::CTL_READ]) begin
            st_reg <= sai_pkg::HS_RD_LO;
          end
        end
        sai_pkg::HS_RD_LO: begin
          if (seq_end) begin
            st_reg <= sai_pkg::HS_RD_HI;
          end
        end
        sai_pkg::HS_WRITE,
        sai_pkg::HS_RD_HI,
        sai_pkg::HS_RESET: begin
          if (seq_end) begin
            st_reg <= sai_pkg::HS_IDLE;
          end
        end
        default: st_reg <= sai_pkg::HS_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cnt_reg <= 4'h0;
    end else if (st_reg == sai_pkg::HS_IDLE || seq_end) begin
      cnt_reg <= 4'h0;
    end else begin
      cnt_reg <= cnt_reg + 4'h1;
    end
  end

  // pins follow state one cycle later, all from flops
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cs_n_reg <= 1'b1;
      wr_n_reg <= 1'b1;
      rd_n_reg <= 1'b1;
      hbs_reg <= 1'b0;
      rst_n_reg <= 1'b1;
    end else begin
      // RL14 select held
      cs_n_reg <= st_reg == sai_pkg::HS_IDLE ||
                  st_reg == sai_pkg::HS_RESET;
      // RL15 convert strobe
      wr_n_reg <= !(st_reg == sai_pkg::HS_WRITE &&
                    cnt_reg < sai_pkg::WR_LOW);
      // RL16 read strobe
      rd_n_reg <= !((st_reg == sai_pkg::HS_RD_LO ||
                     st_reg == sai_pkg::HS_RD_HI) &&
                    cnt_reg < sai_pkg::RD_LOW);
      // RL4 low byte first
      hbs_reg <= st_reg == sai_pkg::HS_RD_HI;
      // RL1 reset pulse
      rst_n_reg <= st_reg != sai_pkg::HS_RESET;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      result_reg <= 16'h0000;
    end else if (cnt_reg == sai_pkg::RD_SAMPLE) begin
      if (st_reg == sai_pkg::HS_RD_LO) begin
        result_reg[7:0] <= syn2_reg[sai_pkg::H_DATA +: 8];
      end else if (st_reg == sai_pkg::HS_RD_HI) begin
        result_reg[15:8] <= syn2_reg[sai_pkg::H_DATA +: 8];
      end
    end
  end

  // serial shift register, msb arrives first
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      serial_reg <= 16'h0000;
    end else if (strb_prev_reg && !syn2_reg[sai_pkg::H_STRB]) begin
      serial_reg <= {serial_reg[14:0], syn2_reg[sai_pkg::H_SDAT]};
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rdata_reg <= 16'h0000;
    end else if (!RD_STB) begin
      rdata_reg <= 16'h0000;
    end else begin
      unique case (ADDR)
        sai_pkg::REG_STATUS: rdata_reg <= {13'h0000,
          st_reg != sai_pkg::HS_IDLE,
          syn2_reg[sai_pkg::H_RDY], syn2_reg[sai_pkg::H_BUSY]};
        sai_pkg::REG_RESULT: rdata_reg <= result_reg;
        sai_pkg::REG_SERIAL: rdata_reg <= serial_reg;
        default:             rdata_reg <= 16'h0000;
      endcase
    end
  end

  assign LINK.cs_n = cs_n_reg;
  assign LINK.wr_n = wr_n_reg;
  assign LINK.rd_n = rd_n_reg;
  assign LINK.high_byte_select = hbs_reg;
  assign LINK.reset_n = rst_n_reg;
  assign RDATA = rdata_reg;
endmodule // sai_host

/* File: tb/sai_checker.sv */
`timescale 1ns/100ps
module sai_checker (
  // system
  input wire logic       CLK,
  input wire logic       RST_N,
  // host driven pins
  input wire logic       cs_n,
  input wire logic       wr_n,
  input wire logic       rd_n,
  input wire logic       high_byte_select,
  input wire logic       reset_n,
  // device driven pins
  input wire logic [7:0] data,
  input wire logic       data_oe,
  input wire logic       data_ready,
  input wire logic       busy,
  input wire logic       ser_data,
  input wire logic       ser_strobe
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  logic [8:0] busy_cnt;
  logic [4:0] fall_cnt;
  // busy cycles of the current conversion
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) busy_cnt <= '0;
    else busy_cnt <= busy ? busy_cnt + 9'h001 : 9'h000;
  end
  // strobe falls, cleared whenever no conversion runs
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) fall_cnt <= '0;
    else if (!busy) fall_cnt <= '0;
    else if ($fell(ser_strobe)) fall_cnt <= fall_cnt + 5'h01;
  end
  sequence s_start;
    $fell(wr_n) && !cs_n && !busy && reset_n;
  endsequence
  sequence s_hi_read;
    $fell(rd_n) && !cs_n && high_byte_select && !busy && reset_n;
  endsequence
  sequence s_done;
    $fell(busy) && reset_n;
  endsequence
  a_busy_start: assert property (s_start |-> ##[1:4] busy)
    else $error("busy late after start");
  a_busy_len: assert property (s_done |-> busy_cnt == 9'h101)
    else $error("busy length wrong");
  a_strobe_count: assert property (s_done |-> fall_cnt == 5'h10)
    else $error("strobe fall count wrong");
  a_strobe_after: assert property ($fell(ser_strobe)
    |-> $past(ser_data, 8) == ser_data)
    else $error("serial bit not held before strobe");
  a_strobe_idle: assert property (!busy |-> ser_strobe)
    else $error("strobe low outside conversion");
  a_done_ready: assert property (s_done |-> data_ready)
    else $error("ready missing at completion");
  a_hi_clears: assert property (s_hi_read |-> ##[1:4] !data_ready)
    else $error("high byte read left ready set");
  a_lo_keeps: assert property (data_ready && !cs_n && !rd_n && reset_n
    && !high_byte_select && !busy |=> data_ready)
    else $error("low byte read cleared ready");
  a_drive_on_read: assert property (data_oe
    |-> !$past(rd_n, 3) && !$past(cs_n, 3))
    else $error("bus driven without a read");
  a_idle_bus: assert property (!data_oe |-> data == 8'h00)
    else $error("data not released");
  a_pin_reset: assert property (!reset_n [*3]
    |=> !data_ready && !busy && !data_oe)
    else $error("reset pin did not clear");
endmodule // sai_checker

/* File: tb/tb_top.sv */
`timescale 1ns/100ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_total++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
  localparam logic [15:0] M_BSY = 16'h0001;
  localparam logic [15:0] M_RDY = 16'h0002;
  localparam logic [15:0] M_ENG = 16'h0004;
  logic        clk;
  logic        rst_n;
  logic [3:0]  addr;
  logic [15:0] wdata;
  logic        wr_stb;
  logic        rd_stb;
  logic [15:0] rdata;
  logic        twos_sel;
  logic [15:0] trial_word;
  logic [15:0] target;
  logic [15:0] latch_m;
  logic [15:0] rv;
  int          err_total;
  int          total_checks;
  int          conv_q[$];
  sai_if sai_if_i ();
  sai_host sai_host_i (.CLK(clk), .RST_N(rst_n), .LINK(sai_if_i.host),
    .ADDR(addr), .WDATA(wdata), .WR_STB(wr_stb), .RD_STB(rd_stb),
    .RDATA(rdata));
  // comparator: keep the trial bit while the trial does not pass the input
  sai_device sai_device_i (.CLK(clk), .RST_N(rst_n), .LINK(sai_if_i.dev),
    .COMP_KEEP(trial_word <= target), .TWOS_SEL(twos_sel),
    .TRIAL_WORD(trial_word));
  sai_checker sai_checker_i (.CLK(clk), .RST_N(rst_n),
    .cs_n(sai_if_i.cs_n), .wr_n(sai_if_i.wr_n), .rd_n(sai_if_i.rd_n),
    .high_byte_select(sai_if_i.high_byte_select),
    .reset_n(sai_if_i.reset_n), .data(sai_if_i.data),
    .data_oe(sai_if_i.data_oe), .data_ready(sai_if_i.data_ready),
    .busy(sai_if_i.busy), .ser_data(sai_if_i.ser_data),
    .ser_strobe(sai_if_i.ser_strobe));
  always #12.5 clk = ~clk;
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr   <= a;
    wdata  <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 rv = rdata;
  endtask
  task automatic poll(input logic [15:0] m, input logic [15:0] v);
    int n;
    n = 0;
    rd(sai_pkg::REG_STATUS);
    while ((rv & m) !== v && n < 2000) begin
      n++;
      rd(sai_pkg::REG_STATUS);
    end
    // a stuck flag ends the run as a failure
    if (n >= 2000) begin
      err_total++;
      $display("[ERR] t=%0t poll stuck got=%h exp=%h", $time, rv & m, v);
      results();
    end
  endtask
  // status lags two cycles, so give the sequencer flag time to show
  task automatic ctrl(input logic [15:0] cmd);
    wr(sai_pkg::REG_CTRL, cmd);
    repeat (4) @(posedge clk);
    poll(M_ENG, 16'h0000);
  endtask
  task automatic convert(input logic [15:0] t, input logic tw);
    @(posedge clk);
    // input held, not timed by busy
    target   <= t;
    twos_sel <= tw;
    repeat (3) @(posedge clk);
    ctrl(16'h0001);
    poll(M_BSY, M_BSY);
    `CHK(rv & M_BSY, M_BSY)
    conv_q.push_back(int'(t ^ (tw ? 16'h8000 : 16'h0000)));
  endtask
  task automatic finish_conv();
    poll(M_BSY, 16'h0000);
    `CHK(rv & M_BSY, 16'h0000)
    latch_m = 16'(conv_q.pop_front());
    `CHK(rv & M_RDY, M_RDY)
    rd(sai_pkg::REG_SERIAL);
    `CHK(rv, latch_m)
  endtask
  task automatic read_word();
    ctrl(16'h0002);
    rd(sai_pkg::REG_RESULT);
  endtask
  task automatic results();
    $display("checks=%0d mismatches=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    $display("[ERR] t=%0t watchdog expired", $time);
    results();
  end
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    addr = '0;
    wdata = '0;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    twos_sel = 1'b0;
    target = '0;
    latch_m = '0;
    err_total = 0;
    total_checks = 0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    void'($urandom(32'hB505));
    // code range ends first, then random codes in both output codings
    for (int i = 0; i < 6; i++) begin
      convert(i == 0 ? 16'h0000 : i == 1 ? 16'hFFFF : 16'($urandom()),
        1'(i));
      finish_conv();
      read_word();
      `CHK(rv, latch_m)
      rd(sai_pkg::REG_STATUS);
      `CHK(rv & M_RDY, 16'h0000)
    end
    $display("test single conversions done");
    // unread word is overwritten and ready stays set
    convert(16'($urandom()), 1'b0);
    finish_conv();
    convert(16'($urandom()), 1'b0);
    finish_conv();
    rd(sai_pkg::REG_STATUS);
    `CHK(rv & M_RDY, M_RDY)
    read_word();
    `CHK(rv, latch_m)
    // old word stays readable while the next conversion runs
    convert(16'($urandom()), 1'b0);
    read_word();
    `CHK(rv, latch_m)
    finish_conv();
    read_word();
    `CHK(rv, latch_m)
    $display("test overwrite and overlap done");
    // reset pin clears ready and the result latch; busy is already low before the reset and is checked to stay low
    convert(16'($urandom()), 1'b0);
    finish_conv();
    ctrl(16'h0004);
    repeat (4) @(posedge clk);
    rd(sai_pkg::REG_STATUS);
    `CHK(rv & (M_RDY | M_BSY), 16'h0000)
    read_word();
    `CHK(rv, 16'h0000)
    $display("test reset done");
    results();
  end
endmodule // tb_top
